// ---- common/tcc_pkg.sv ----
// package: register map, field layout, modes and clamp minimums for trace capture control
package tcc_pkg;
    // register byte offsets (one aligned 32-bit word each)
    localparam logic [3:0] TCC_OFF_CTRL = 4'h0;     // mode, match kind, family, stop_when_full
    localparam logic [3:0] TCC_OFF_AFTER = 4'h4;    // after_count
    localparam logic [3:0] TCC_OFF_POST = 4'h8;     // post_trigger_count
    localparam logic [3:0] TCC_OFF_STATUS = 4'hc;   // capture state and write pointer
    // control word field positions
    localparam int TCC_CTRL_MODE_LSB = 0;           // 3-bit tracepoint mode
    localparam int TCC_CTRL_DATA_BIT = 4;           // 1: data read/write match, 0: instruction
    localparam int TCC_CTRL_FAM_LSB = 8;            // 2-bit target variant
    localparam int TCC_CTRL_WRAP_BIT = 12;          // stop_when_full
    localparam int TCC_CTRL_RUN_BIT = 16;           // write 1: run command (arm), self clearing
    localparam int TCC_CTRL_HALT_BIT = 17;          // write 1: target suspended, self clearing
    // reset values
    localparam logic [15:0] TCC_AFTER_RST = 16'h0000;
    localparam logic [15:0] TCC_POST_RST = 16'h0000;
    localparam logic TCC_WRAP_RST = 1'b0;           // default: circular overwrite
    // clamp minimums
    localparam logic [15:0] TCC_MIN_0F = 16'h000f;
    localparam logic [15:0] TCC_MIN_10 = 16'h0010;
    localparam logic [15:0] TCC_MIN_20 = 16'h0020;
    localparam logic [15:0] TCC_MIN_100 = 16'h0100;
    localparam logic [15:0] TCC_ZERO = 16'h0000;
    // width of the per-record instruction count field; records carry 1..64 instructions
    localparam int TCC_INSN_W = 7;

    // tracepoint modes
    typedef enum logic [2:0] {
        TCC_MODE_NONE = 3'h0,   // no tracepoint: capture everything
        TCC_MODE_ON = 3'h1,     // start on match
        TCC_MODE_OFF = 3'h2,    // stop on match (+ after_count)
        TCC_MODE_ONOFF = 3'h3,  // paired start and stop
        TCC_MODE_AROUND = 3'h4, // match record + after_count
        TCC_MODE_TRIG = 3'h5    // stop on match + post count, hold till run
    } tcc_mode_t;

    // target variants
    typedef enum logic [1:0] {
        TCC_FAM_CF = 2'h0,      // small-record family
        TCC_FAM_A405 = 2'h1,    // first variant of the other family
        TCC_FAM_A440 = 2'h2     // second variant of the other family
    } tcc_fam_t;

    // capture states, gray along idle->wait->cap->post->done
    typedef enum logic [2:0] {
        TCC_ST_IDLE = 3'b000,
        TCC_ST_WAIT = 3'b001,
        TCC_ST_CAP = 3'b011,
        TCC_ST_POST = 3'b010,
        TCC_ST_DONE = 3'b110
    } tcc_state_t;
endpackage

// ---- design/tcc_trace_ctrl.sv ----
// trace capture controller: tracepoint modes, post counters, wrap/stop buffer writes
`timescale 1ns/1ps
// Function
// - no tracepoint: record everything until suspend
// - after event capture exactly after_count records
// - after_count used only in off/around modes
// - post_trigger_count used only in trigger mode
// - records carry a variable instruction count
// - around data match clamps after_count minimum
// - trigger data match clamps post count minimum
// - off data match clamps after_count minimum
// - paired on/off instruction forces after_count zero
// - around instruction match clamps per variant
// - off instruction match clamps after_count minimum
// - trigger instruction match clamps post minimum
// - stop_when_full with on mode stops at end
// - otherwise wrap pointer and overwrite oldest
// - on mode starts capture with match record
// - trigger stop holds until next run command
// - around stores match record plus after_count at the first match, the match record only at later ones
module tcc_trace_ctrl
    import tcc_pkg::*;
#(
    parameter int DEPTH_W = 12,                 // trace buffer address width
    parameter int REC_W = 32                    // trace record width
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,                     // low freezes all state
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // trace record stream from the target port (same clock)
    input wire logic recValid,                  // one record this cycle
    input wire logic [REC_W-1:0] recData,       // record payload
    input wire logic [TCC_INSN_W-1:0] recInsns, // instructions covered, 1..64
    input wire logic recMatch,                  // armed address matched on this record
    // buffer readout for the host
    input wire logic [DEPTH_W-1:0] bufRdAddr,
    output logic [REC_W-1:0] bufRdData,
    output logic [TCC_INSN_W-1:0] bufRdInsns,
    output logic capturing                      // a record is stored when valid
);
    localparam int DEPTH = 1 << DEPTH_W;

    // host-visible settings
    tcc_mode_t mode_r;                          // armed mode
    logic dataMatch_r;                          // match kind
    tcc_fam_t fam_r;                            // target variant
    logic stopWhenFull_r;
    logic [15:0] afterCount_r;                  // held as written
    logic [15:0] postTrigCount_r;
    // working state
    tcc_state_t state_r;
    tcc_state_t state_nxt;
    logic [15:0] remain_r;                      // records still to keep after the event
    logic [15:0] remain_nxt;
    logic [DEPTH_W-1:0] wrPtr_r;
    logic wrapped_r;                            // buffer has filled once
    logic [REC_W-1:0] memData [DEPTH];          // the trace buffer itself
    logic [TCC_INSN_W-1:0] memInsns [DEPTH];
    logic ack_r;                                // bus answer one cycle after request

    // counters and the wrap flag hold exactly what the host wrote;
    // the floors of each mode are applied only when a run arms the
    // controller, so a read-back never shows a clamped value and the
    // host can change mode without losing its own counter settings
    // limitation: the clamp is taken once at arm time, so a counter
    // write during a capture only matters for the next run
    // clamp to a minimum
    function automatic logic [15:0] atLeast(input logic [15:0] v, input logic [15:0] m);
        return (v < m) ? m : v;
    endfunction

    // effective after_count for the armed mode
    // order matters: data-match floors are tested before the
    // instruction floors, and the paired mode wins over any value
    // modes that do not use after_count get zero, so the shared
    // remain counter can be loaded with an or of both clamps
    function automatic logic [15:0] clampAfter(input tcc_mode_t md, input logic dm,
                                               input tcc_fam_t f, input logic [15:0] v);
        logic cf;
        cf = (f == TCC_FAM_CF);
        if (md == TCC_MODE_AROUND && dm) begin
            return atLeast(v, cf ? TCC_MIN_0F : TCC_MIN_20);
        end else if (md == TCC_MODE_OFF && dm) begin
            return atLeast(v, cf ? TCC_MIN_0F : TCC_MIN_20);
        end else if (md == TCC_MODE_ONOFF) begin
            return TCC_ZERO;
        end else if (md == TCC_MODE_AROUND) begin
            return atLeast(v, cf ? TCC_MIN_0F :
                              (f == TCC_FAM_A440) ? TCC_MIN_100 : TCC_MIN_20);
        end else if (md == TCC_MODE_OFF) begin
            return atLeast(v, cf ? TCC_MIN_0F : TCC_MIN_10);
        end
        return TCC_ZERO;
    endfunction

    // effective post_trigger_count; data and instruction minimums coincide
    // only the trigger mode sees a nonzero value here
    function automatic logic [15:0] clampPost(input tcc_mode_t md, input tcc_fam_t f,
                                              input logic [15:0] v);
        if (md != TCC_MODE_TRIG) begin
            return TCC_ZERO;
        end
        return atLeast(v, (f == TCC_FAM_CF) ? TCC_MIN_0F : TCC_MIN_10);
    endfunction

    // bus decode
    // every strobe is gated by the write acknowledge, so a write lands
    // on the single edge at which waitrequest is seen low
    wire busReq = (read || write) && clkEn;
    wire wrStb = write && ack_r && clkEn;
    wire selCtrl = (address == TCC_OFF_CTRL);
    wire selAfter = (address == TCC_OFF_AFTER);
    wire selPost = (address == TCC_OFF_POST);
    wire selStat = (address == TCC_OFF_STATUS);
    wire runCmd = wrStb && selCtrl && byteenable[2] && writedata[TCC_CTRL_RUN_BIT];
    wire haltCmd = wrStb && selCtrl && byteenable[2] && writedata[TCC_CTRL_HALT_BIT];
    // settings as they stand after this edge: a run command may share
    // its word with the mode, match kind and variant it arms
    // hazard avoided: arming from the old mode would clamp and start
    // the capture for whatever mode was set before this write
    wire ctrlLo = wrStb && selCtrl && byteenable[0];
    wire ctrlMid = wrStb && selCtrl && byteenable[1];
    tcc_mode_t armMode;                         // mode that this run arms
    logic armData;                              // match kind that this run arms
    tcc_fam_t armFam;                           // variant that this run arms
    assign armMode = ctrlLo ? tcc_mode_t'(writedata[TCC_CTRL_MODE_LSB +: 3]) : mode_r;
    assign armData = ctrlLo ? writedata[TCC_CTRL_DATA_BIT] : dataMatch_r;
    assign armFam = ctrlMid ? tcc_fam_t'(writedata[TCC_CTRL_FAM_LSB +: 2]) : fam_r;
    // last buffer location; the pointer wraps past it
    wire atEnd = (wrPtr_r == DEPTH_W'(DEPTH - 1));
    // stop_when_full only bites with start-on-match
    wire stopFull = stopWhenFull_r && (mode_r == TCC_MODE_ON);
    wire [31:0] ctrlWord = {14'h0000, 2'b00, 3'b000, stopWhenFull_r, 2'b00, fam_r,
                            3'b000, dataMatch_r, 1'b0, mode_r};
    wire [31:0] statWord = {wrapped_r, 12'h000, state_r, DEPTH_W'(0) | 16'(wrPtr_r)};

    // waitrequest drops one cycle after a request is presented
    // the wait cycle lets readdata be registered before it is taken,
    // at the cost of one extra cycle on every access
    assign waitrequest = (read || write) && !ack_r;

    // single-cycle wait then acknowledge; cleared on the following edge
    // ack clears itself on the answer edge, so a request that stays
    // up into a second transfer gets its own wait cycle again
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else if (clkEn) begin
            ack_r <= busReq && !ack_r;
        end
    end

    // read data registered; unmapped offsets read zero
    // loaded on the wait cycle and held until the next read, so it
    // stands at the edge where the master takes it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (clkEn && read && !ack_r) begin
            readdata <= selCtrl ? ctrlWord :
                        selAfter ? {16'h0000, afterCount_r} :
                        selPost ? {16'h0000, postTrigCount_r} :
                        selStat ? statWord : 32'h0000_0000;
        end
    end

    // host writes; byte lanes honoured
    // disabled lanes keep their old bytes; the run and halt bits sit
    // in lane two and are strobes only, never stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= TCC_MODE_NONE;
            dataMatch_r <= 1'b0;
            fam_r <= TCC_FAM_CF;
            stopWhenFull_r <= TCC_WRAP_RST;
            afterCount_r <= TCC_AFTER_RST;
            postTrigCount_r <= TCC_POST_RST;
        end else if (wrStb) begin
            if (selCtrl && byteenable[0]) begin
                mode_r <= tcc_mode_t'(writedata[TCC_CTRL_MODE_LSB +: 3]);
                dataMatch_r <= writedata[TCC_CTRL_DATA_BIT];
            end
            if (selCtrl && byteenable[1]) begin
                fam_r <= tcc_fam_t'(writedata[TCC_CTRL_FAM_LSB +: 2]);
                stopWhenFull_r <= writedata[TCC_CTRL_WRAP_BIT];
            end
            if (selAfter && byteenable[0]) afterCount_r[7:0] <= writedata[7:0];
            if (selAfter && byteenable[1]) afterCount_r[15:8] <= writedata[15:8];
            if (selPost && byteenable[0]) postTrigCount_r[7:0] <= writedata[7:0];
            if (selPost && byteenable[1]) postTrigCount_r[15:8] <= writedata[15:8];
        end
    end

    // capture sequencing
    // idle: nothing armed; wait: armed, looking for the match;
    // cap: storing every record; post: counting the kept records
    // after the event; done: stopped until the host runs again
    // capturing is combinational so that the match record itself is
    // stored in the cycle it arrives
    always_comb begin
        state_nxt = state_r;
        remain_nxt = remain_r;
        capturing = 1'b0;
        unique case (state_r)
            TCC_ST_IDLE: begin
                capturing = 1'b0;                       // not running
            end
            TCC_ST_WAIT: begin
                // on, paired and around modes wait for the match
                if (recValid && recMatch) begin
                    capturing = 1'b1;                   // match record is first stored
                    if (mode_r == TCC_MODE_AROUND) begin
                        state_nxt = (remain_r == TCC_ZERO) ? TCC_ST_WAIT : TCC_ST_POST;
                    end else begin
                        state_nxt = TCC_ST_CAP;
                    end
                end
            end
            TCC_ST_CAP: begin
                capturing = recValid;
                if (recValid && recMatch && mode_r != TCC_MODE_NONE && mode_r != TCC_MODE_ON)
                begin
                    // paired mode: first event was the start, this one stops
                    state_nxt = (remain_r == TCC_ZERO) ?
                                ((mode_r == TCC_MODE_ONOFF) ? TCC_ST_WAIT : TCC_ST_DONE) :
                                TCC_ST_POST;
                end
                if (recValid && stopFull && atEnd) begin
                    state_nxt = TCC_ST_DONE;
                end
            end
            TCC_ST_POST: begin
                // keep exactly the counted records after the event
                capturing = recValid;
                if (recValid) begin
                    remain_nxt = remain_r - 16'h0001;
                    if (remain_r == 16'h0001) begin
                        state_nxt = (mode_r == TCC_MODE_AROUND) ? TCC_ST_WAIT : TCC_ST_DONE;
                    end
                end
            end
            TCC_ST_DONE: begin
                capturing = 1'b0;                       // held until next run
            end
            default: begin
                state_nxt = TCC_ST_IDLE;
            end
        endcase
    end

    // state, counter and pointer; run arms and clamps, halt ends capture
    // run wins over halt when both bits are written together
    // the pointer restarts at zero on every run, which empties the
    // buffer without clearing it: old records are only overwritten
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= TCC_ST_IDLE;
            remain_r <= TCC_ZERO;
            wrPtr_r <= '0;
            wrapped_r <= 1'b0;
        end else if (clkEn) begin
            if (runCmd) begin
                // clamp at arm time from the held values
                remain_r <= clampAfter(armMode, armData, armFam, afterCount_r) |
                            clampPost(armMode, armFam, postTrigCount_r);
                state_r <= (armMode == TCC_MODE_NONE || armMode == TCC_MODE_OFF ||
                            armMode == TCC_MODE_TRIG) ? TCC_ST_CAP : TCC_ST_WAIT;
                wrPtr_r <= '0;
                wrapped_r <= 1'b0;
            end else if (haltCmd) begin
                state_r <= TCC_ST_IDLE;
            end else begin
                state_r <= state_nxt;
                remain_r <= (state_r == TCC_ST_POST) ? remain_nxt : remain_r;
                if (capturing) begin
                    wrPtr_r <= wrPtr_r + DEPTH_W'(1);
                    if (atEnd) wrapped_r <= 1'b1;
                end
            end
        end
    end

    // buffer write and registered readout
    // no reset on the array: its contents are don't-care until written
    // readout is one cycle behind the address and may be read while
    // capture runs; a read of the write location returns the old word
    always_ff @(posedge clk) begin
        if (clkEn && capturing) begin
            memData[wrPtr_r] <= recData;
            memInsns[wrPtr_r] <= recInsns;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bufRdData <= '0;
            bufRdInsns <= '0;
        end else if (clkEn) begin
            bufRdData <= memData[bufRdAddr];
            bufRdInsns <= memInsns[bufRdAddr];
        end
    end
endmodule // tcc_trace_ctrl

// ---- sim/tcc_trace_ctrl_monitor.sv ----
// checker: bus handshake and capture gating of the trace controller
`timescale 1ns/1ps
module tcc_trace_ctrl_monitor
    import tcc_pkg::*;
#(parameter int DEPTH_W = 12, parameter int REC_W = 32) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic recValid,
    input wire logic [REC_W-1:0] recData,
    input wire logic [TCC_INSN_W-1:0] recInsns,
    input wire logic recMatch,
    input wire logic [DEPTH_W-1:0] bufRdAddr,
    input wire logic [REC_W-1:0] bufRdData,
    input wire logic [TCC_INSN_W-1:0] bufRdInsns,
    input wire logic capturing
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // full-word control write completing at this edge
    wire logic ctrlAck = write && !waitrequest && address == TCC_OFF_CTRL && byteenable == 4'hf;
    wire logic runCmd = ctrlAck && writedata[TCC_CTRL_RUN_BIT];
    wire logic haltCmd = ctrlAck && writedata[TCC_CTRL_HALT_BIT];
    logic idle_r; // no run since reset or halt
    logic onWait_r; // start-on-match armed, no match yet
    logic none_r; // armed with no tracepoint
    // shadow of the arm state, kept from bus traffic and record matches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idle_r <= 1'b1;
            onWait_r <= 1'b0;
            none_r <= 1'b0;
        end else if (runCmd) begin
            idle_r <= 1'b0;
            onWait_r <= writedata[2:0] == TCC_MODE_ON;
            none_r <= writedata[2:0] == TCC_MODE_NONE;
        end else if (haltCmd) begin
            idle_r <= 1'b1;
            onWait_r <= 1'b0;
            none_r <= 1'b0;
        end else if (recValid && recMatch) begin
            onWait_r <= 1'b0;
        end
    end
    a_wait_first: assert property ($rose(read || write) |-> waitrequest)
        else $error("new request answered without a wait cycle");
    a_wait_ack: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    a_wait_idle: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest high with no request");
    a_read_stable: assert property ($changed(readdata) |-> $past(read && waitrequest))
        else $error("readdata changed without a read");
    a_cap_valid: assert property (capturing |-> recValid)
        else $error("capture without a record");
    a_idle_quiet: assert property (idle_r |-> !capturing)
        else $error("capture while not running");
    a_on_wait: assert property (onWait_r && recValid && clkEn |-> capturing == recMatch)
        else $error("start-on-match began at the wrong record");
    a_none_all: assert property (none_r && recValid && clkEn |-> capturing)
        else $error("record dropped with no tracepoint");
endmodule // tcc_trace_ctrl_monitor
bind tcc_trace_ctrl tcc_trace_ctrl_monitor #(.DEPTH_W(DEPTH_W), .REC_W(REC_W)) uMon (
    .clk(clk), .rst(rst), .clkEn(clkEn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .recValid(recValid), .recData(recData), .recInsns(recInsns),
    .recMatch(recMatch), .bufRdAddr(bufRdAddr), .bufRdData(bufRdData),
    .bufRdInsns(bufRdInsns), .capturing(capturing));

// ---- sim/tcc_trace_ctrl_tb.sv ----
// testbench: registers, tracepoint modes, count clamps and buffer wrap
`timescale 1ns/1ps
module tcc_trace_ctrl_tb
    import tcc_pkg::*;
;
    localparam int DW = 4; // 16-record buffer keeps wrap short
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1; // never frozen here
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata, recData, bufRdData;
    logic waitrequest, recValid, recMatch, capturing, srcDone;
    logic [6:0] recInsns, bufRdInsns;
    logic [DW-1:0] bufRdAddr = '0;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic [15:0] nRec = 16'h1, matchA = 16'hffff, matchB = 16'hffff;
    logic [6:0] insnMax = 7'h10;
    int capCnt = 0, mismatches = 0, nTests = 0, cyc = 0;
    int seed = 32'h09b4;
    int modes[3] = '{2, 4, 5};
    always #50 clk = ~clk;
    tcc_trace_ctrl #(.DEPTH_W(DW), .REC_W(32)) uut (.clk(clk), .rst(rst), .clkEn(clkEn),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .recValid(recValid), .recData(recData), .recInsns(recInsns), .recMatch(recMatch),
        .bufRdAddr(bufRdAddr), .bufRdData(bufRdData), .bufRdInsns(bufRdInsns),
        .capturing(capturing));
    tcc_trace_src uSrc (.clk(clk), .rst(rst), .start(start), .slow(slow), .nRec(nRec),
        .matchA(matchA), .matchB(matchB), .insnMax(insnMax), .recValid(recValid),
        .recData(recData), .recInsns(recInsns), .recMatch(recMatch), .done(srcDone));
    // count stored records; cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (capturing === 1'b1) capCnt <= capCnt + 1;
        if (cyc == 40000) begin
            mismatches++;
            endSim();
        end
    end
    task automatic endSim();
        $display("counts: tests %0d mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        nTests++;
        if (got !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask
    // one avalon transfer: held until waitrequest is seen low at an edge
    task automatic busOp(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        int k;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= w;
        read <= !w;
        k = 0;
        @(negedge clk);
        while (waitrequest !== 1'b0 && k < 50) begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic bufChk(input int ad, input int e);
        @(posedge clk);
        bufRdAddr <= ad[DW-1:0];
        @(posedge clk);
        @(negedge clk);
        chk("buffer", 32'(e), bufRdData);
    endtask
    // records stored in all, up to and including the event (only the event record in around mode) plus those kept after it, with the floors applied at arm
    function automatic int expCnt(input int m, d, f, a, p, mA);
        int mn;
        mn = (f == 0) ? 15 : 16;
        if (m == 2 && d == 1 && f != 0) mn = 32;
        if (m == 4 && f != 0) mn = (d == 1 || f == 1) ? 32 : 256;
        if (m == 5) return mA + 1 + (p < mn ? mn : p);
        if (m == 2) return mA + 1 + (a < mn ? mn : a);
        return 1 + (a < mn ? mn : a);
    endfunction
    // arm, stream n records, suspend, compare the stored count
    task automatic runCase(input int m, d, f, wr, a, p, mA, mB, n, e);
        logic [31:0] cfg, q;
        int k;
        cfg = 32'((wr << TCC_CTRL_WRAP_BIT) | (f << TCC_CTRL_FAM_LSB) | (d << 4) | m);
        busOp(1'b1, TCC_OFF_AFTER, 32'(a), 4'hf, q);
        busOp(1'b1, TCC_OFF_POST, 32'(p), 4'hf, q);
        busOp(1'b1, TCC_OFF_CTRL, cfg | (32'h1 << TCC_CTRL_RUN_BIT), 4'hf, q);
        @(posedge clk);
        capCnt <= 0;
        matchA <= 16'(mA);
        matchB <= 16'(mB);
        nRec <= 16'(n);
        slow <= 1'($random(seed));
        insnMax <= (f == 2) ? 7'h40 : 7'h10;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        k = 0;
        @(negedge clk);
        while (srcDone !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        repeat (4) @(posedge clk);
        busOp(1'b1, TCC_OFF_CTRL, cfg | (32'h1 << TCC_CTRL_HALT_BIT), 4'hf, q);
        chk("captured", 32'(e), 32'(capCnt));
    endtask
    initial begin
        logic [31:0] q, v;
        logic [3:0] ad;
        int a, p, mA;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        busOp(1'b0, TCC_OFF_AFTER, 32'h0, 4'hf, q);
        chk("after reset", {16'h0, TCC_AFTER_RST}, q);
        busOp(1'b0, TCC_OFF_CTRL, 32'h0, 4'hf, q);
        chk("wrap reset", 32'(TCC_WRAP_RST), 32'(q[TCC_CTRL_WRAP_BIT]));
        busOp(1'b0, TCC_OFF_STATUS, 32'h0, 4'hf, q);
        chk("idle state", 32'(TCC_ST_IDLE), 32'(q[18:16]));
        busOp(1'b1, 4'h1, 32'hffff_ffff, 4'hf, q);
        busOp(1'b0, 4'h1, 32'h0, 4'hf, q);
        chk("unmapped", 32'h0, q);
        // random word, then a low-lane write over it
        for (int i = 0; i < 4; i++) begin
            ad = i[0] ? TCC_OFF_POST : TCC_OFF_AFTER;
            v = $random(seed);
            busOp(1'b1, ad, v, 4'hf, q);
            busOp(1'b1, ad, 32'h0000_005a, 4'h1, q);
            busOp(1'b0, ad, 32'h0, 4'hf, q);
            chk("counter", {16'h0, v[15:8], 8'h5a}, q);
        end
        // every counting mode, both match kinds, all variants
        foreach (modes[j]) for (int d = 0; d < 2; d++) for (int f = 0; f < 3; f++) begin
            a = $random(seed) & 32'h3f;
            p = $random(seed) & 32'h3f;
            mA = 1 + ($random(seed) & 7);
            runCase(modes[j], d, f, 0, a, p, mA, (modes[j] == 5) ? mA + 200 : 16'hffff,
                mA + 300, expCnt(modes[j], d, f, a, p, mA));
        end
        runCase(1, 0, 1, 1, 0, 0, 3, 16'hffff, 40, 16);
        bufChk(0, 3);
        bufChk(15, 18);
        runCase(3, 0, 2, 0, 5, 0, 2, 9, 30, 8);
        runCase(0, 0, 0, 0, 7, 7, 16'hffff, 16'hffff, 20, 20);
        bufChk(0, 16);
        bufChk(5, 5);
        endSim();
    end
endmodule // tcc_trace_ctrl_tb

// ---- sim/tcc_trace_src.sv ----
// partner: target trace port sending numbered records
`timescale 1ns/1ps
module tcc_trace_src
    import tcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic slow,
    input wire logic [15:0] nRec,
    input wire logic [15:0] matchA,
    input wire logic [15:0] matchB,
    input wire logic [TCC_INSN_W-1:0] insnMax,
    output logic recValid,
    output logic [31:0] recData,
    output logic [TCC_INSN_W-1:0] recInsns,
    output logic recMatch,
    output logic done
);
    logic [15:0] seq_r; // number of the next record
    logic active_r; // burst in progress
    int seed = 32'h05a3; // own seed so gaps repeat
    assign done = !active_r;
    // records go out back to back, or with random gaps when slow
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_r <= 1'b0;
            seq_r <= 16'h0;
            recValid <= 1'b0;
            recData <= 32'h0;
            recInsns <= '0;
            recMatch <= 1'b0;
        end else begin
            recValid <= 1'b0;
            recMatch <= 1'b0;
            recData <= ~recData; // idle lines toggle, never a stale copy
            recInsns <= ~recInsns;
            if (start) begin
                active_r <= 1'b1;
                seq_r <= 16'h0;
            end else if (active_r && (!slow || $random(seed) % 2 != 0)) begin
                recValid <= 1'b1;
                recData <= {16'h0, seq_r};
                recInsns <= TCC_INSN_W'(1 + {$random(seed)} % insnMax);
                recMatch <= seq_r == matchA || seq_r == matchB;
                seq_r <= seq_r + 16'h1;
                active_r <= seq_r + 16'h1 != nRec;
            end
        end
    end
endmodule // tcc_trace_src
